// [core/fws_params.svh]
// Functional notes
// - Host starts with two back-to-back reads; unchanged toggle bit means done.
// - Still toggling with timing limit high: recheck; still toggling means failure, reset.
// - Host returning from other work restarts the toggle check from its double read.
// - After any timing-limit failure the host sends the reset command.
// - Host issuing sector erases under 50 us apart may ignore the erase timer flag.
// - Host checks erase timer flag before and after each extra sector erase command; this host only reports it from the last read as status bit 4.
// - Host presents a valid address when reading polling bit or toggle bit two.
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH
`define FWS_IDX_CMD 3'h0
`define FWS_IDX_ADDR 3'h1
`define FWS_IDX_WDATA 3'h2
`define FWS_IDX_STATUS 3'h3
`define FWS_IDX_RDATA 3'h4
`define FWS_CMD_READ 3'h1
`define FWS_CMD_WRITE 3'h2
`define FWS_CMD_POLL 3'h3
`define FWS_CMD_RESET 3'h4
`define FWS_CMD_SEL_BIT 3
`define FWS_BIT_POLL 7
`define FWS_BIT_TGL1 6
`define FWS_BIT_LIMIT 5
`define FWS_BIT_TIMER 3
`define FWS_BIT_TGL2 2
`define FWS_ST_BUSY 0
`define FWS_ST_RES_LO 1
`define FWS_ST_RES_HI 2
`define FWS_ST_READY 3
`define FWS_ST_TIMER 4
`define FWS_ST_LIMIT 5
`define FWS_RESET_DATA 16'h00f0
`define FWS_RESET_ADDR 20'h00000
`define FWS_CLK_NS 5
`define FWS_SETUP_NS 10
`define FWS_STROBE_NS 100
`define FWS_HOLD_NS 20
`define FWS_CYC(ns) (((ns) + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`endif

// [core/fws_pkg.sv]
package fws_pkg;
  typedef enum logic [1:0] {FWS_PH_IDLE, FWS_PH_SETUP, FWS_PH_STROBE, FWS_PH_HOLD} fws_phase_type;
  typedef enum logic [2:0] {FWS_ST_IDLE, FWS_ST_SINGLE, FWS_ST_POLL_A, FWS_ST_POLL_B,
    FWS_ST_RECHK_A, FWS_ST_RECHK_B, FWS_ST_RESET} fws_state_type;
  typedef enum logic [1:0] {FWS_RES_NONE, FWS_RES_OK, FWS_RES_FAIL} fws_result_type;
endpackage

// [core/fws_bus_cycle.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fws_params.svh"
module fws_bus_cycle (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic we,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] flash_dq_in,
  output logic done,
  output logic [15:0] rdata,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic chip_select_n,
  output logic output_strobe_n,
  output logic write_strobe_n
);
  localparam logic [7:0] SETUP_CYC = 8'(`FWS_CYC(`FWS_SETUP_NS));
  localparam logic [7:0] STROBE_CYC = 8'(`FWS_CYC(`FWS_STROBE_NS));
  localparam logic [7:0] HOLD_CYC = 8'(`FWS_CYC(`FWS_HOLD_NS));

  fws_pkg::fws_phase_type phase_reg, phase_next;
  logic [7:0] cnt_reg, cnt_next;
  logic we_reg, we_next;
  logic done_reg, cs_n_reg, oe_n_reg, we_n_reg, dq_oe_reg;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg, rdata_reg, dq_meta_reg, dq_sync_reg;

  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    we_next = we_reg;
    if (phase_reg != fws_pkg::FWS_PH_IDLE && cnt_reg != 8'h00) begin
      cnt_next = cnt_reg - 8'h01;
    end else begin
      unique case (phase_reg)
        fws_pkg::FWS_PH_IDLE: begin
          if (req) begin
            phase_next = fws_pkg::FWS_PH_SETUP;
            cnt_next = SETUP_CYC - 8'h01;
            we_next = we;
          end
        end
        fws_pkg::FWS_PH_SETUP: begin
          phase_next = fws_pkg::FWS_PH_STROBE;
          cnt_next = STROBE_CYC - 8'h01;
        end
        fws_pkg::FWS_PH_STROBE: begin
          phase_next = fws_pkg::FWS_PH_HOLD;
          cnt_next = HOLD_CYC - 8'h01;
        end
        fws_pkg::FWS_PH_HOLD: begin
          phase_next = fws_pkg::FWS_PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= fws_pkg::FWS_PH_IDLE;
      cnt_reg <= 8'h00;
      we_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      we_reg <= we_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
    end else if (phase_reg == fws_pkg::FWS_PH_IDLE && req) begin
      addr_reg <= addr;
      wdata_reg <= wdata;
    end
  end

  // pins follow the next phase so they change together with it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cs_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
    end else begin
      cs_n_reg <= phase_next == fws_pkg::FWS_PH_IDLE;
      oe_n_reg <= we_next || phase_next == fws_pkg::FWS_PH_IDLE
                  || phase_next == fws_pkg::FWS_PH_HOLD;
      we_n_reg <= !(we_next && phase_next == fws_pkg::FWS_PH_STROBE);
      dq_oe_reg <= we_next && phase_next != fws_pkg::FWS_PH_IDLE;
    end
  end

  // strobe is far longer than the two sync stages, so data has settled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_meta_reg <= 16'h0000;
      dq_sync_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      dq_meta_reg <= flash_dq_in;
      dq_sync_reg <= dq_meta_reg;
      if (phase_reg == fws_pkg::FWS_PH_STROBE && cnt_reg == 8'h00 && !we_reg) begin
        rdata_reg <= dq_sync_reg;
      end
      done_reg <= phase_reg == fws_pkg::FWS_PH_HOLD && cnt_reg == 8'h00;
    end
  end

  assign done = done_reg;
  assign rdata = rdata_reg;
  assign flash_addr = addr_reg;
  assign flash_dq_out = wdata_reg;
  assign flash_dq_oe = dq_oe_reg;
  assign chip_select_n = cs_n_reg;
  assign output_strobe_n = oe_n_reg;
  assign write_strobe_n = we_n_reg;
endmodule
`default_nettype wire

// [core/fws_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fws_params.svh"
module fws_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic chip_select_n,
  output logic output_strobe_n,
  output logic write_strobe_n,
  input wire logic ready_busy_n
);
  fws_pkg::fws_state_type st_reg;
  fws_pkg::fws_result_type res_reg;
  logic wr_pend_reg;
  logic [2:0] wr_idx_reg;
  logic [31:0] hrdata_reg;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg, last_reg;
  logic [2:0] cmd_reg;
  logic sel_two_reg, go_reg, first_reg;
  logic eng_req_reg, eng_we_reg;
  logic [19:0] eng_addr_reg;
  logic [15:0] eng_wdata_reg;
  logic eng_done;
  logic [15:0] eng_rdata;
  logic rb_meta_reg, rb_sync_reg;
  logic tgl_now, busy;

  function automatic logic [31:0] read_mux(input logic [2:0] idx);
    unique case (idx)
      `FWS_IDX_ADDR: read_mux = {12'h000, addr_reg};
      `FWS_IDX_WDATA: read_mux = {16'h0000, wdata_reg};
      `FWS_IDX_STATUS: begin
        read_mux = 32'h00000000;
        read_mux[`FWS_ST_BUSY] = busy;
        read_mux[`FWS_ST_RES_HI:`FWS_ST_RES_LO] = res_reg;
        read_mux[`FWS_ST_READY] = rb_sync_reg;
        read_mux[`FWS_ST_TIMER] = last_reg[`FWS_BIT_TIMER];
        read_mux[`FWS_ST_LIMIT] = last_reg[`FWS_BIT_LIMIT];
      end
      `FWS_IDX_RDATA: read_mux = {16'h0000, last_reg};
      default: read_mux = 32'h00000000;
    endcase
  endfunction

  assign busy = st_reg != fws_pkg::FWS_ST_IDLE || go_reg;
  // toggle bit under test; bit two only tells selected sectors apart
  assign tgl_now = sel_two_reg ? eng_rdata[`FWS_BIT_TGL2] : eng_rdata[`FWS_BIT_TGL1];

  // ahb slave: zero wait states, read data prepared at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 3'h0;
      hrdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready) begin
        wr_idx_reg <= haddr[4:2];
        hrdata_reg <= haddr[31:5] == 27'h0000000 ? read_mux(haddr[4:2]) : 32'h00000000;
      end
    end
  end

  // register writes; all writes arriving while busy are dropped, addr and wdata as well as commands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
      cmd_reg <= 3'h0;
      sel_two_reg <= 1'b0;
      go_reg <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (wr_pend_reg && !busy) begin
        unique case (wr_idx_reg)
          `FWS_IDX_CMD: begin
            cmd_reg <= hwdata[2:0];
            sel_two_reg <= hwdata[`FWS_CMD_SEL_BIT];
            go_reg <= hwdata[2:0] != 3'h0;
          end
          `FWS_IDX_ADDR: addr_reg <= hwdata[19:0];
          `FWS_IDX_WDATA: wdata_reg <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rb_meta_reg <= 1'b1;
      rb_sync_reg <= 1'b1;
    end else begin
      rb_meta_reg <= ready_busy_n;
      rb_sync_reg <= rb_meta_reg;
    end
  end

  // sequencer: single cycles, toggle polling and the failure reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= fws_pkg::FWS_ST_IDLE;
      res_reg <= fws_pkg::FWS_RES_NONE;
      first_reg <= 1'b0;
      last_reg <= 16'h0000;
      eng_req_reg <= 1'b0;
      eng_we_reg <= 1'b0;
      eng_addr_reg <= 20'h00000;
      eng_wdata_reg <= 16'h0000;
    end else begin
      eng_req_reg <= 1'b0;
      if (eng_done && !eng_we_reg) begin
        last_reg <= eng_rdata;
      end
      unique case (st_reg)
        fws_pkg::FWS_ST_IDLE: begin
          if (go_reg) begin
            res_reg <= fws_pkg::FWS_RES_NONE;
            eng_req_reg <= 1'b1;
            eng_addr_reg <= addr_reg;
            eng_wdata_reg <= wdata_reg;
            eng_we_reg <= cmd_reg == `FWS_CMD_WRITE;
            if (cmd_reg == `FWS_CMD_POLL) begin
              st_reg <= fws_pkg::FWS_ST_POLL_A;
            end else if (cmd_reg == `FWS_CMD_RESET) begin
              eng_we_reg <= 1'b1;
              eng_addr_reg <= `FWS_RESET_ADDR;
              eng_wdata_reg <= `FWS_RESET_DATA;
              st_reg <= fws_pkg::FWS_ST_SINGLE;
            end else begin
              st_reg <= fws_pkg::FWS_ST_SINGLE;
            end
          end
        end
        fws_pkg::FWS_ST_SINGLE: begin
          if (eng_done) begin
            res_reg <= fws_pkg::FWS_RES_OK;
            st_reg <= fws_pkg::FWS_ST_IDLE;
          end
        end
        fws_pkg::FWS_ST_POLL_A, fws_pkg::FWS_ST_RECHK_A: begin
          if (eng_done) begin
            first_reg <= tgl_now;
            eng_req_reg <= 1'b1;
            st_reg <= st_reg == fws_pkg::FWS_ST_POLL_A ? fws_pkg::FWS_ST_POLL_B
                                                       : fws_pkg::FWS_ST_RECHK_B;
          end
        end
        fws_pkg::FWS_ST_POLL_B: begin
          if (eng_done) begin
            eng_req_reg <= tgl_now != first_reg;
            if (tgl_now == first_reg) begin
              res_reg <= fws_pkg::FWS_RES_OK;
              st_reg <= fws_pkg::FWS_ST_IDLE;
            end else if (eng_rdata[`FWS_BIT_LIMIT]) begin
              st_reg <= fws_pkg::FWS_ST_RECHK_A;
            end else begin
              // each round starts over with a fresh pair of reads
              st_reg <= fws_pkg::FWS_ST_POLL_A;
            end
          end
        end
        fws_pkg::FWS_ST_RECHK_B: begin
          if (eng_done) begin
            if (tgl_now == first_reg) begin
              res_reg <= fws_pkg::FWS_RES_OK;
              st_reg <= fws_pkg::FWS_ST_IDLE;
            end else begin
              eng_req_reg <= 1'b1;
              eng_we_reg <= 1'b1;
              eng_addr_reg <= `FWS_RESET_ADDR;
              eng_wdata_reg <= `FWS_RESET_DATA;
              st_reg <= fws_pkg::FWS_ST_RESET;
            end
          end
        end
        fws_pkg::FWS_ST_RESET: begin
          if (eng_done) begin
            res_reg <= fws_pkg::FWS_RES_FAIL;
            st_reg <= fws_pkg::FWS_ST_IDLE;
          end
        end
        default: st_reg <= fws_pkg::FWS_ST_IDLE;
      endcase
    end
  end

  fws_bus_cycle u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(eng_req_reg),
    .we(eng_we_reg),
    .addr(eng_addr_reg),
    .wdata(eng_wdata_reg),
    .flash_dq_in(flash_dq_in),
    .done(eng_done),
    .rdata(eng_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .chip_select_n(chip_select_n),
    .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
endmodule
`default_nettype wire

// [verification/fws_host_props.sv]
`timescale 1ns/1ps
`default_nettype none
module fws_host_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic chip_select_n,
  input wire logic output_strobe_n,
  input wire logic write_strobe_n
);
  logic [7:0] we_cnt;
  logic [7:0] oe_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // low-time counters, read at the strobe's rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      we_cnt <= 8'h00;
    end else begin
      we_cnt <= write_strobe_n ? 8'h00 : we_cnt + 8'h01;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_cnt <= 8'h00;
    end else begin
      oe_cnt <= output_strobe_n ? 8'h00 : oe_cnt + 8'h01;
    end
  end
  sequence hold_s;
    (!chip_select_n)[*4] ##1 chip_select_n;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  strobe_excl_a: assert property (!(!output_strobe_n && !write_strobe_n))
    else $error("both strobes low");
  strobe_select_a: assert property ((!output_strobe_n || !write_strobe_n) |-> !chip_select_n)
    else $error("strobe without chip select");
  addr_stable_a: assert property (!chip_select_n && $past(!chip_select_n) |-> $stable(flash_addr))
    else $error("address moved in cycle");
  wdata_stable_a: assert property (!write_strobe_n |-> flash_dq_oe && $stable(flash_dq_out))
    else $error("write data not held");
  read_float_a: assert property (!output_strobe_n |-> !flash_dq_oe)
    else $error("host drives data during read");
  write_setup_a: assert property ($fell(write_strobe_n) |-> $past(!chip_select_n, 2))
    else $error("write setup too short");
  write_width_a: assert property ($rose(write_strobe_n) |-> we_cnt == 8'h14)
    else $error("write strobe width wrong");
  read_width_a: assert property ($rose(output_strobe_n) |-> oe_cnt == 8'h16)
    else $error("read strobe width wrong");
  write_hold_a: assert property ($rose(write_strobe_n) |-> hold_s)
    else $error("write hold wrong");
endmodule
bind fws_host fws_host_props u_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .chip_select_n(chip_select_n),
  .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n));
`default_nettype wire

// [verification/fws_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model (
  input wire logic chip_select_n,
  input wire logic output_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic [3:0] busy_reads,
  input wire logic fail,
  input wire logic erase_mode,
  output logic [15:0] dq,
  output logic ready_busy_n
);
  logic [15:0] mem [0:15];
  logic [15:0] last, pd;
  logic [3:0] left, pa;
  logic busy, tgl, limit, erasing;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
    {busy, tgl, limit, erasing, left, pa, pd, last, dq} = '0;
  end
  assign ready_busy_n = !busy;
  // any other write while idle starts an operation; status valid from this edge on
  always @(posedge write_strobe_n) if (!chip_select_n) begin
    if (flash_dq_out == 16'h00f0) begin
      busy = 1'h0;
      limit = 1'h0;
    end else if (!busy) begin
      busy = 1'h1;
      left = busy_reads;
      erasing = erase_mode;
      pa = flash_addr[3:0];
      pd = flash_dq_out;
    end
  end
  // select and address change in the same step as the strobe: let them settle first
  always @(negedge output_strobe_n) begin
    #1;
    if (!chip_select_n) begin
      if (busy) begin
        tgl = !tgl;
        last = 16'h0000;
        last[7] = erasing ? 1'h0 : !pd[7];
        last[6] = tgl;
        last[5] = limit;
        last[3] = erasing;
        last[2] = erasing & tgl;
        if (left != 4'h0) left = left - 4'h1;
        else if (fail) limit = 1'h1;
        else begin
          busy = 1'h0;
          // top slot is protected: status runs its course, nothing is written
          if (pa != 4'hf) begin
            mem[pa] = erasing ? 16'hffff : mem[pa] & pd;
          end
        end
      end else last = mem[flash_addr[3:0]];
      dq = last;
    end
  end
  // released bus shows the inverse so a stale value never passes
  always @(posedge output_strobe_n or posedge chip_select_n) dq = ~last;
endmodule
`default_nettype wire

// [verification/tb_flash_write_status_reporting.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_flash_write_status_reporting;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, r1;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic flash_dq_oe, chip_select_n, output_strobe_n, write_strobe_n, ready_busy_n;
  logic [3:0] busy_reads;
  logic fail, erase_mode;
  int err_total, n_checks;
  fws_host DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n), .ready_busy_n(ready_busy_n));
  fws_flash_model u_flash (.chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .busy_reads(busy_reads), .fail(fail), .erase_mode(erase_mode), .dq(flash_dq_in),
    .ready_busy_n(ready_busy_n));
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] idx, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {27'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // leaves the last status word in rd; gives up after 2000 more reads and counts an error
  task automatic wait_idle;
    int n;
    n = 0;
    bus(1'h0, 3'h3, 32'h0);
    while (rd[0] !== 1'h0 && n < 2000) begin
      bus(1'h0, 3'h3, 32'h0);
      n++;
    end
    if (rd[0] !== 1'h0) begin
      err_total++;
      $display("[ERR] t=%0t busy=%h exp=%h", $time, rd[0], 1'h0);
    end
  endtask
  task automatic cmd(input logic [31:0] c);
    bus(1'h1, 3'h0, c);
    wait_idle;
  endtask
  task automatic read_flash;
    cmd(32'h1);
    bus(1'h0, 3'h4, 32'h0);
  endtask
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, hresetn, busy_reads, fail, erase_mode} = '0;
    hsize = 3'h2;
    err_total = 0;
    n_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, 3'h3, 32'h0);
    chk(rd, 32'h8);
    bus(1'h0, 3'h5, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    busy_reads <= 4'h3;
    bus(1'h1, 3'h1, 32'h5);
    bus(1'h1, 3'h2, 32'h0);
    bus(1'h1, 3'h0, 32'h2);
    bus(1'h1, 3'h1, 32'h9);
    wait_idle;
    chk(rd & 32'h8, 32'h0);
    read_flash;
    r1 = rd;
    chk(rd & 32'hffbf, 32'h80);
    read_flash;
    chk({31'h0, rd[6]}, {31'h0, ~r1[6]});
    cmd(32'h3);
    chk(rd, 32'ha);
    bus(1'h0, 3'h1, 32'h0);
    chk(rd, 32'h5);
    read_flash;
    chk(rd, 32'h0);
    $display("test program poll done");
    fail <= 1'h1;
    busy_reads <= 4'h2;
    bus(1'h1, 3'h1, 32'h6);
    cmd(32'h2);
    cmd(32'h3);
    chk(rd, 32'h2c);
    fail <= 1'h0;
    read_flash;
    chk(rd, 32'hffff);
    $display("test limit failure done");
    erase_mode <= 1'h1;
    busy_reads <= 4'h4;
    bus(1'h1, 3'h1, 32'h7);
    cmd(32'h2);
    read_flash;
    chk(rd & 32'hbb, 32'h8);
    cmd(32'hb);
    chk(rd, 32'h3a);
    erase_mode <= 1'h0;
    $display("test erase poll done");
    busy_reads <= 4'h1;
    bus(1'h1, 3'h1, 32'hf);
    cmd(32'h2);
    cmd(32'h3);
    chk(rd, 32'h3a);
    read_flash;
    chk(rd, 32'hffff);
    $display("test protected program done");
    stop_test;
  end
  initial begin
    #400000;
    err_total++;
    stop_test;
  end
endmodule
`default_nettype wire
